// ===== core/pmd_pkg.sv
// Purpose: shared constants and types for the PHY-side MII data path
// Assumes: system clock of 100 MHz; MII clocks derived from it
// Notes:   the list below sums up the MII data path's operation
// Operation
// - TXD bit zero is the least significant bit on both sides.
// - PHY sources TX_CLK: 2.5 MHz at 10 Mbps, 25 MHz at 100 Mbps.
// - PHY drives RXD in step with RX_CLK, bit zero least significant.
// - PHY raises RX_DV with RX_CLK while RXD holds valid data.
// - PHY raises RX_ER with RX_CLK when a receive error is seen.
// - PHY sources RX_CLK: 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps.
// - COL rises when a collision starts and stays high throughout.
// - COL ignores both MII clocks and stays low in full duplex.
// - Half duplex: CRS high while transmitting or receiving.
// - Full duplex: CRS high only while receiving.
// - CRS may rise anytime but falls only on an RX_CLK edge.
package pmd_pkg;

    // clock rates
    localparam int unsigned SYS_HZ     = 100_000_000;
    localparam int unsigned MII_100_HZ = 25_000_000;
    localparam int unsigned MII_10_HZ  = 2_500_000;

    // divider half periods in system cycles
    localparam int unsigned DIV_W    = 5;
    localparam logic [4:0]  HALF_100 = DIV_W'(SYS_HZ / (2 * MII_100_HZ));
    localparam logic [4:0]  HALF_10  = DIV_W'(SYS_HZ / (2 * MII_10_HZ));

    // nibble field layout, bit zero least significant
    localparam int unsigned NIB_W   = 4;
    localparam int unsigned WORD_W  = NIB_W + 1;

    // reset values
    localparam logic [3:0] NIB_RST = 4'h0;

    // one nibble with its error flag
    typedef struct packed {
        logic       err;
        logic [3:0] data;
    } pmd_nib_t;

endpackage

// ===== core/pmd_buf.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes:   read data come straight out of a storage register
`timescale 1ns/1ns
module pmd_buf
#(
    parameter int unsigned WIDTH = 5
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    logic [WIDTH-1:0] mem_reg [2];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    // honest full and empty flags from the occupancy count
    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];

    // storage; no reset needed on data words
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
        end
    end

endmodule

// ===== core/pmd_mii.sv
// Purpose: PHY-side MII data path with clock generation, CRS and COL
// Assumes: MAC pins arrive from outside the system clock domain
// Notes:   TX_CLK and RX_CLK share one divider and one phase
`timescale 1ns/1ns
module pmd_mii
(
    // system
    input  wire logic             CLK_SYS,
    input  wire logic             NRST,
    input  wire logic             CE,
    // configuration levels
    input  wire logic             SPEED_100,
    input  wire logic             FULL_DUPLEX,
    // line side receive stream
    input  wire logic             LINE_CARRIER,
    input  wire logic             LINE_RX_VALID,
    output logic                  LINE_RX_READY,
    input  wire pmd_pkg::pmd_nib_t LINE_RX,
    // line side transmit stream
    output logic                  LINE_TX_VALID,
    output logic                  LINE_TX_ACTIVE,
    output pmd_pkg::pmd_nib_t     LINE_TX,
    // MII transmit pins
    output logic                  TX_CLK,
    input  wire logic [3:0]       TXD,
    input  wire logic             TX_EN,
    input  wire logic             TX_ER,
    // MII receive pins
    output logic                  RX_CLK,
    output logic [3:0]            RXD,
    output logic                  RX_DV,
    output logic                  RX_ER,
    // MII status pins
    output logic                  COL,
    output logic                  CRS
);

    logic [4:0]        cnt_reg;
    logic [4:0]        half_reg;
    logic              mii_clk_reg;
    logic              toggle;
    logic              rise_tick;
    logic              fall_tick;
    logic [5:0]        tx_meta_reg;
    logic [5:0]        tx_sync_reg;
    logic              tx_en_s;
    logic              tx_valid_reg;
    logic              tx_active_reg;
    pmd_pkg::pmd_nib_t tx_word_reg;
    logic              buf_valid;
    pmd_pkg::pmd_nib_t buf_data;
    logic [3:0]        rxd_reg;
    logic              rx_dv_reg;
    logic              rx_er_reg;
    logic              col_reg;
    logic              crs_reg;
    logic              crs_want;

    // divider half period picked by speed
    function automatic logic [4:0] half_of(input logic fast);
        return fast ? pmd_pkg::HALF_100 : pmd_pkg::HALF_10;
    endfunction

    assign toggle    = CE && (cnt_reg == 5'(half_reg - 5'h01));
    assign rise_tick = toggle && !mii_clk_reg;
    assign fall_tick = toggle && mii_clk_reg;

    // divider; speed is taken only at a toggle, so no runt half period
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            cnt_reg     <= 5'h00;
            half_reg    <= pmd_pkg::HALF_10;
            mii_clk_reg <= 1'b0;
        end
        else if (CE)
        begin
            if (toggle)
            begin
                cnt_reg     <= 5'h00;
                half_reg    <= half_of(SPEED_100);
                mii_clk_reg <= ~mii_clk_reg;
            end
            else
            begin
                cnt_reg <= 5'(cnt_reg + 5'h01);
            end
        end
    end

    assign TX_CLK = mii_clk_reg;
    assign RX_CLK = mii_clk_reg;

    // two-flop synchroniser for the MAC transmit pins
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            tx_meta_reg <= 6'h00;
            tx_sync_reg <= 6'h00;
        end
        else if (CE)
        begin
            tx_meta_reg <= {TX_ER, TX_EN, TXD};
            tx_sync_reg <= tx_meta_reg;
        end
    end

    assign tx_en_s = tx_sync_reg[4];

    // capture at our rise: synced pins hold what the MAC launched before
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            tx_valid_reg  <= 1'b0;
            tx_active_reg <= 1'b0;
            tx_word_reg   <= '0;
        end
        else if (CE)
        begin
            tx_valid_reg <= rise_tick && tx_sync_reg[4];
            if (rise_tick)
            begin
                tx_active_reg     <= tx_sync_reg[4];
                tx_word_reg.data  <= tx_sync_reg[3:0];
                tx_word_reg.err   <= tx_sync_reg[5];
            end
        end
    end

    assign LINE_TX_VALID  = tx_valid_reg;
    assign LINE_TX_ACTIVE = tx_active_reg;
    assign LINE_TX        = tx_word_reg;

    // receive buffer; drained once per MII clock period only
    pmd_buf
    #(
        .WIDTH (pmd_pkg::WORD_W)
    )
    u_rx_buf
    (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .ce        (CE),
        .in_valid  (LINE_RX_VALID),
        .in_ready  (LINE_RX_READY),
        .in_data   (LINE_RX),
        .out_valid (buf_valid),
        .out_ready (fall_tick),
        .out_data  (buf_data)
    );

    // receive pins change on the falling edge, stable for MAC rising edge
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            rxd_reg   <= pmd_pkg::NIB_RST;
            rx_dv_reg <= 1'b0;
            rx_er_reg <= 1'b0;
        end
        else if (CE && fall_tick)
        begin
            rxd_reg   <= buf_valid ? buf_data.data
                                   : pmd_pkg::NIB_RST;
            rx_dv_reg <= buf_valid;
            rx_er_reg <= buf_valid && buf_data.err;
        end
    end

    assign RXD   = rxd_reg;
    assign RX_DV = rx_dv_reg;
    assign RX_ER = rx_er_reg;

    // collision in half duplex, per system cycle, free of the MII clock
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            col_reg <= 1'b0;
        end
        else if (CE)
        begin
            col_reg <= !FULL_DUPLEX && tx_en_s
                       && LINE_CARRIER;
        end
    end

    assign COL = col_reg;

    // carrier sense: own transmission counts in half duplex only
    assign crs_want = LINE_CARRIER
                      || (!FULL_DUPLEX && tx_en_s);

    // rise at once, fall only on the receive clock edge
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            crs_reg <= 1'b0;
        end
        else if (CE)
        begin
            if (crs_want)
            begin
                crs_reg <= 1'b1;
            end
            else if (fall_tick)
            begin
                crs_reg <= 1'b0;
            end
        end
    end

    assign CRS = crs_reg;

    // checks on the divider, receive pins and status outputs
    property p_div_toggle;
        @(posedge CLK_SYS) disable iff (!NRST)
        $changed(mii_clk_reg) |-> $past(CE && cnt_reg == 5'(half_reg - 5'h01));
    endproperty
    a_div_toggle: assert property (p_div_toggle)
        else $error("mii clock toggled off the divider count");

    property p_div_half;
        @(posedge CLK_SYS) disable iff (!NRST)
        $changed(mii_clk_reg) |-> half_reg == (($past(SPEED_100))
            ? pmd_pkg::HALF_100 : pmd_pkg::HALF_10);
    endproperty
    a_div_half: assert property (p_div_half)
        else $error("divider half period does not match speed");

    property p_rxd_edge;
        @(posedge CLK_SYS) disable iff (!NRST)
        $changed(rxd_reg) |-> $past(fall_tick);
    endproperty
    a_rxd_edge: assert property (p_rxd_edge)
        else $error("RXD changed away from the clock edge");

    property p_dv_follows;
        @(posedge CLK_SYS) disable iff (!NRST)
        fall_tick && buf_valid
            |=> rx_dv_reg && rxd_reg == $past(buf_data.data);
    endproperty
    a_dv_follows: assert property (p_dv_follows)
        else $error("RX_DV or RXD missed a buffered nibble");

    property p_er_only_dv;
        @(posedge CLK_SYS) disable iff (!NRST)
        rx_er_reg |-> rx_dv_reg && ($stable(rx_er_reg) || $past(fall_tick));
    endproperty
    a_er_only_dv: assert property (p_er_only_dv)
        else $error("RX_ER moved off the edge or without RX_DV");

    property p_col_on;
        @(posedge CLK_SYS) disable iff (!NRST)
        CE && !FULL_DUPLEX && tx_en_s && LINE_CARRIER |=> col_reg;
    endproperty
    a_col_on: assert property (p_col_on)
        else $error("COL missed a collision");

    property p_col_fdx;
        @(posedge CLK_SYS) disable iff (!NRST)
        CE && FULL_DUPLEX |=> !col_reg;
    endproperty
    a_col_fdx: assert property (p_col_fdx)
        else $error("COL raised in full duplex");

    property p_crs_hdx_tx;
        @(posedge CLK_SYS) disable iff (!NRST)
        CE && !FULL_DUPLEX && tx_en_s |=> crs_reg;
    endproperty
    a_crs_hdx_tx: assert property (p_crs_hdx_tx)
        else $error("CRS low while transmitting in half duplex");

    property p_crs_cause;
        @(posedge CLK_SYS) disable iff (!NRST)
        $rose(crs_reg) |-> $past(LINE_CARRIER || (!FULL_DUPLEX && tx_en_s));
    endproperty
    a_crs_cause: assert property (p_crs_cause)
        else $error("CRS rose without a cause");

    property p_crs_fdx;
        @(posedge CLK_SYS) disable iff (!NRST)
        CE && FULL_DUPLEX && !LINE_CARRIER && !crs_reg |=> !crs_reg;
    endproperty
    a_crs_fdx: assert property (p_crs_fdx)
        else $error("CRS raised by own transmission in full duplex");

    property p_crs_fall;
        @(posedge CLK_SYS) disable iff (!NRST)
        $fell(crs_reg) |-> $past(fall_tick) && !$past(crs_want);
    endproperty
    a_crs_fall: assert property (p_crs_fall)
        else $error("CRS fell away from the receive clock edge");

endmodule

// ===== verification/pmd_mac_model.sv
// Purpose: MAC stand-in on the MII pins of the PHY data path
// Assumes: drives on TX_CLK rise, samples receive on RX_CLK rise
// Notes:   released TXD flips so a stale nibble never passes as data
`timescale 1ns/1ns
module pmd_mac_model
(
    // clocks from the PHY
    input  wire logic       TX_CLK,
    input  wire logic       RX_CLK,
    // receive pins
    input  wire logic [3:0] RXD,
    input  wire logic       RX_DV,
    input  wire logic       RX_ER,
    // transmit pins
    output logic [3:0]      TXD,
    output logic            TX_EN,
    output logic            TX_ER
);
    logic [4:0] rx_q[$];

    // idle pins at time zero
    initial
    begin
        TXD   = 4'h5;
        TX_EN = 1'b0;
        TX_ER = 1'b0;
    end

    // one nibble per transmit period, error flag beside it
    task automatic send(input logic [4:0] w);
        @(posedge TX_CLK);
        #1;
        TXD   = w[3:0];
        TX_ER = w[4];
        TX_EN = 1'b1;
    endtask

    // release the transmit pins on a clock edge
    task automatic idle();
        @(posedge TX_CLK);
        #1;
        TX_EN = 1'b0;
        TX_ER = 1'b0;
        TXD   = ~TXD;
    endtask

    // the MAC samples receive pins on the rising edge
    always @(posedge RX_CLK)
    begin
        if (RX_DV === 1'b1)
        begin
            rx_q.push_back({RX_ER, RXD});
        end
    end
endmodule

// ===== verification/tb_pmd_mii.sv
// Purpose: self-checking bench for the PHY-side MII data path
// Assumes: inputs change 1 ns after the system clock rises
// Notes:   a MAC model stands on the MII pins
`timescale 1ns/1ns
module tb_pmd_mii;
    logic              clk_sys = 1'b0;
    logic              nrst = 1'b0;
    logic              ce = 1'b1;
    logic              spd = 1'b0;
    logic              fd = 1'b0;
    logic              carrier = 1'b0;
    logic              rx_valid = 1'b0;
    pmd_pkg::pmd_nib_t rx_word = 5'h00;
    pmd_pkg::pmd_nib_t tx_word;
    logic              rx_ready, tx_valid, tx_active, tx_clk, rx_clk;
    logic              tx_en, tx_er, rx_dv, rx_er, col, crs, rx_prev;
    logic [3:0]        txd, rxd;
    logic [4:0]        tx_q[$];
    int                err_count = 0;
    int                cmp_count = 0;

    // system clock of 100 MHz
    always #5 clk_sys = ~clk_sys;

    pmd_mii u_dut (.CLK_SYS(clk_sys), .NRST(nrst), .CE(ce),
        .SPEED_100(spd), .FULL_DUPLEX(fd), .LINE_CARRIER(carrier),
        .LINE_RX_VALID(rx_valid), .LINE_RX_READY(rx_ready),
        .LINE_RX(rx_word), .LINE_TX_VALID(tx_valid),
        .LINE_TX_ACTIVE(tx_active), .LINE_TX(tx_word), .TX_CLK(tx_clk),
        .TXD(txd), .TX_EN(tx_en), .TX_ER(tx_er), .RX_CLK(rx_clk),
        .RXD(rxd), .RX_DV(rx_dv), .RX_ER(rx_er), .COL(col), .CRS(crs));

    pmd_mac_model u_mac (.TX_CLK(tx_clk), .RX_CLK(rx_clk), .RXD(rxd),
        .RX_DV(rx_dv), .RX_ER(rx_er), .TXD(txd), .TX_EN(tx_en),
        .TX_ER(tx_er));

    // collect captured transmit words; remember the last RX_CLK level
    always @(posedge clk_sys)
    begin
        rx_prev <= rx_clk;
        if (tx_valid === 1'b1)
        begin
            tx_q.push_back(tx_word);
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // period of TX_CLK in system cycles, then RX_CLK high just after its rise
    task automatic t_clock(input logic s, input logic [7:0] exp);
        time t0;
        spd = s;
        repeat (3) @(posedge tx_clk);
        t0 = $time;
        @(posedge tx_clk);
        chk("mii period", exp, 8'(($time - t0) / 10));
        #1;
        chk("rx_clk", 8'h01, rx_clk);
        $display("test clock done");
    endtask

    // a low enable must freeze the divider; 50 cycles span many halves
    task automatic t_freeze();
        logic c;
        ce = 1'b0;
        c = tx_clk;
        tick(50);
        chk("frozen clk", 8'(c), 8'(tx_clk));
        ce = 1'b1;
        tick(2);
        $display("test freeze done");
    endtask

    // frame of three nibbles, one with the error flag
    task automatic t_tx();
        logic [4:0] exp[3] = '{5'h01, 5'h18, 5'h0A};
        tx_q.delete();
        foreach (exp[i]) u_mac.send(exp[i]);
        chk("tx_active on", 8'h01, tx_active);
        u_mac.idle();
        tick(10);
        chk("tx count", 8'h03, 8'(tx_q.size()));
        foreach (exp[i]) chk("line_tx", exp[i], tx_q[i]);
        chk("tx_active", 8'h00, tx_active);
        $display("test transmit done");
    endtask

    // overfill the two-entry buffer, then drain it through RXD
    task automatic t_rx();
        logic [4:0] w[4] = '{5'h03, 5'h1C, 5'h06, 5'h19};
        logic       refused = 1'b0;
        u_mac.rx_q.delete();
        foreach (w[i])
        begin
            rx_valid = 1'b1;
            rx_word = w[i];
            while (rx_ready !== 1'b1)
            begin
                refused = 1'b1;
                tick(1);
            end
            tick(1);
        end
        rx_valid = 1'b0;
        tick(40);
        chk("refused", 8'h01, refused);
        chk("rx count", 8'h04, 8'(u_mac.rx_q.size()));
        foreach (w[i]) chk("rx word", w[i], u_mac.rx_q[i]);
        $display("test receive done");
    endtask

    // collision and carrier sense in one duplex mode
    task automatic t_sense(input logic f);
        int n;
        fd = f;
        carrier = 1'b1;
        u_mac.send(5'h0F);
        tick(8);
        chk("col", 8'(!f), col);
        chk("crs", 8'h01, crs);
        carrier = 1'b0;
        tick(8);
        chk("col off", 8'h00, col);
        chk("crs own tx", 8'(!f), crs);
        u_mac.idle();
        carrier = 1'b1;
        tick(8);
        carrier = 1'b0;
        n = 0;
        while (crs !== 1'b0 && n < 20)
        begin
            n++;
            tick(1);
        end
        chk("crs fall", 8'h02, {rx_prev, rx_clk});
        $display("test sense done");
    endtask

    // watchdog on a span well past the tests
    initial
    begin
        #500_000;
        err_count++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        tick(4);
        nrst = 1'b1;
        tick(2);
        t_clock(1'b0, 8'd40);
        t_clock(1'b1, 8'd4);
        t_freeze();
        t_tx();
        t_rx();
        t_sense(1'b0);
        t_sense(1'b1);
        report_and_stop();
    end
endmodule
